/* File: tb_usb_rx_endpoint_ctl_status.sv */
// Testbench for the receive endpoint control and status block
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_ep_params.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_usb_rx_endpoint_ctl_status;
  import usb_rx_ep_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [11:0] address_i = '0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [3:0] byteenable_i = 4'hF;
  logic [3:0] be = 4'hF;
  logic [31:0] writedata_i = '0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  link_evt_t evt_i;
  logic toggle_clear_o;
  logic send_stall_o;
  logic fifo_flush_o;
  logic irq_o;
  int err_count = 0;
  int checks_done = 0;
  int n0;
  logic exp_clr;
  usb_rx_ep_ctl usb_rx_ep_ctl_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .evt_i(evt_i), .toggle_clear_o(toggle_clear_o), .send_stall_o(send_stall_o),
    .fifo_flush_o(fifo_flush_o), .irq_o(irq_o));
  usb_rx_host_model usb_rx_host_model_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .send_stall_i(send_stall_o), .toggle_clear_i(toggle_clear_o),
    .fifo_flush_i(fifo_flush_o), .evt_o(evt_i));
  // Clock generator, 100 ns period
  initial forever #50 clk_sys_i = ~clk_sys_i;
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One Avalon-MM cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clk_sys_i);
    address_i <= {idx, 2'b00};
    write_i <= wr;
    read_i <= !wr;
    writedata_i <= wd;
    byteenable_i <= be;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      finish_test();
    end
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] ex, input string nm);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    `CHK(nm, ex, rd)
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rdchk(`RX_EP1_LOW_IDX, 32'h00, "low reset");
    rdchk(`RX_EP1_HIGH_IDX, 32'h00, "high reset");
    rdchk(`MAXP_IDX, 32'h40, "maxp reset");
    rdchk(10'h3FF, 32'h00, "unmapped");
    $display("test reset done");
    wr(`IRQ_MASK_IDX, 32'h01);
    usb_rx_host_model_i.out_xfer(1'b0);
    `CHK("irq", 1'b1, irq_o)
    wr(`RX_EP1_LOW_IDX, 32'h81);
    rdchk(`RX_EP1_LOW_IDX, 32'h01, "ready kept");
    `CHK("toggle", 1'b0, usb_rx_host_model_i.data_tog)
    wr(`RX_EP1_LOW_IDX, 32'h00);
    rdchk(`RX_EP1_LOW_IDX, 32'h00, "ready clr");
    wr(`IRQ_STAT_IDX, 32'h01);
    `CHK("irq clr", 1'b0, irq_o)
    wr(`IRQ_MASK_IDX, 32'h00);
    usb_rx_host_model_i.out_xfer(1'b0);
    `CHK("irq masked", 1'b0, irq_o)
    rdchk(`IRQ_STAT_IDX, 32'h01, "irq stat");
    wr(`IRQ_STAT_IDX, 32'h01);
    n0 = usb_rx_host_model_i.flush_cnt;
    wr(`RX_EP1_LOW_IDX, 32'h11);
    repeat (2) @(posedge clk_sys_i);
    `CHK("flush", n0 + 1, usb_rx_host_model_i.flush_cnt)
    rdchk(`RX_EP1_LOW_IDX, 32'h00, "flush ready");
    $display("test ready done");
    wr(`RX_EP1_LOW_IDX, 32'h20);
    `CHK("stall on", 1'b1, send_stall_o)
    usb_rx_host_model_i.out_xfer(1'b0);
    rdchk(`RX_EP1_LOW_IDX, 32'h60, "stall sent");
    wr(`RX_EP1_LOW_IDX, 32'h40);
    `CHK("stall off", 1'b0, send_stall_o)
    rdchk(`RX_EP1_LOW_IDX, 32'h40, "stall kept");
    wr(`RX_EP1_LOW_IDX, 32'h00);
    rdchk(`RX_EP1_LOW_IDX, 32'h00, "stall clr");
    be = 4'hE;
    wr(`RX_EP1_LOW_IDX, 32'h20);
    be = 4'hF;
    `CHK("lane off", 1'b0, send_stall_o)
    usb_rx_host_model_i.set_full(1'b1);
    rdchk(`RX_EP1_LOW_IDX, 32'h02, "full");
    usb_rx_host_model_i.set_full(1'b0);
    rdchk(`RX_EP1_LOW_IDX, 32'h00, "not full");
    $display("test stall done");
    wr(`MODE_CFG_IDX, 32'h02);
    wr(`RX_EP1_LOW_IDX, 32'h20);
    `CHK("iso stall", 1'b0, send_stall_o)
    wr(`RX_EP1_LOW_IDX, 32'h00);
    usb_rx_host_model_i.out_xfer(1'b1);
    rdchk(`RX_EP1_LOW_IDX, 32'h09, "data err");
    usb_rx_host_model_i.drop();
    rdchk(`RX_EP1_LOW_IDX, 32'h0D, "overrun");
    wr(`RX_EP1_LOW_IDX, 32'h04);
    rdchk(`RX_EP1_LOW_IDX, 32'h04, "err clr");
    wr(`RX_EP1_LOW_IDX, 32'h00);
    rdchk(`RX_EP1_LOW_IDX, 32'h00, "over clr");
    wr(`MODE_CFG_IDX, 32'h00);
    usb_rx_host_model_i.out_xfer(1'b1);
    usb_rx_host_model_i.drop();
    rdchk(`RX_EP1_LOW_IDX, 32'h01, "bulk zero");
    wr(`RX_EP1_LOW_IDX, 32'h00);
    $display("test iso done");
    wr(`RX_EP2_HIGH_IDX, 32'h80);
    rdchk(`RX_EP2_HIGH_IDX, 32'h80, "ep2 high");
    wr(`RX_EP3_HIGH_IDX, 32'h80);
    rdchk(`RX_EP3_HIGH_IDX, 32'h80, "ep3 high");
    wr(`MODE_CFG_IDX, 32'h01);
    wr(`RX_EP1_HIGH_IDX, 32'h80);
    rdchk(`RX_EP1_HIGH_IDX, 32'h80, "ep1 high");
    for (int m = 61; m <= 64; m++) begin
      wr(`MAXP_IDX, m);
      for (int s = 0; s < 5; s++) begin
        for (int d = 0; d < 2; d++) begin
          usb_rx_host_model_i.out_xfer(1'b0);
          usb_rx_host_model_i.unload(d[0], 11'(m - s));
          exp_clr = d ? (s <= ((m % 4 == 0) ? 3 : m % 4 - 1)) : (s == 0);
          rdchk(`RX_EP1_LOW_IDX, {31'h0, !exp_clr}, "auto clear");
          wr(`RX_EP1_LOW_IDX, 32'h00);
        end
      end
    end
    be = 4'h3;
    wr(`MAXP_IDX, 32'h13F);
    be = 4'hF;
    usb_rx_host_model_i.out_xfer(1'b0);
    usb_rx_host_model_i.unload(1'b0, 11'h13F);
    rdchk(`RX_EP1_LOW_IDX, 32'h00, "maxp lane 1");
    $display("test auto clear done");
    wr(`MODE_CFG_IDX, 32'h00);
    wr(`RX_EP1_LOW_IDX, 32'h20);
    `CHK("stall again", 1'b1, send_stall_o)
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    `CHK("reset stall", 1'b0, send_stall_o)
    rdchk(`RX_EP1_HIGH_IDX, 32'h00, "high rerun");
    rdchk(`MAXP_IDX, 32'h40, "maxp rerun");
    $display("test rerun done");
    finish_test();
  end
endmodule
`default_nettype wire

/* File: usb_rx_ep_ctl.sv */
// Receive endpoint control and status registers with Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_ep_params.svh"

module usb_rx_ep_ctl #(
  parameter int MAXP_W = 11
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    srst_i,
  // Avalon-MM slave
  input  wire logic [11:0]             address_i,
  input  wire logic                    read_i,
  input  wire logic                    write_i,
  input  wire logic [3:0]              byteenable_i,
  input  wire logic [31:0]             writedata_i,
  output logic      [31:0]             readdata_o,
  output logic                         waitrequest_o,
  // Packet engine
  input  wire usb_rx_ep_pkg::link_evt_t evt_i,
  output logic                         toggle_clear_o,
  output logic                         send_stall_o,
  output logic                         fifo_flush_o,
  // Interrupt
  output logic                         irq_o
);
  import usb_rx_ep_pkg::*;

  ctl_state_t st;
  ctl_state_t next_st;
  logic       do_wr;
  logic [7:0] wd;
  logic       low_wr;
  logic       ready_clr;
  logic       auto_hit;

  // Reset image of the state: all clear, max packet at its default
  localparam ctl_state_t RST_ST = '{
    phase:   BUS_HOLD,
    max_pkt: `MAXP_RESET,
    default: '0
  };

  // ********************************************************
  // Helper functions
  // ********************************************************

  // Byte address match against a register index
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  // Unloaded length that lets auto-clear drop packet-ready
  function automatic logic len_clears(input logic [10:0] len, input logic [10:0] maxp,
                                      input logic dma);
    logic [1:0]  rem;
    logic [10:0] slack;
    rem   = maxp[1:0];
    slack = maxp - len;
    if (!dma) begin
      len_clears = (len == maxp);
    end else if (len > maxp) begin
      len_clears = 1'b0;
    end else if (rem == 2'h0) begin
      len_clears = (slack <= 11'h003);
    end else begin
      len_clears = (slack <= {9'h000, rem - 2'h1});
    end
  endfunction

  // Register read multiplexer
  function automatic logic [7:0] rd_mux(input ctl_state_t s, input logic [11:0] addr,
                                        input logic full);
    logic [7:0] v;
    v = 8'h00;
    if (hit(addr, `RX_EP1_LOW_IDX)) begin
      v[`LOW_STALL_SENT] = s.stall_sent;
      v[`LOW_SEND_STALL] = s.stall_req;
      v[`LOW_DATA_ERR]   = s.data_err & s.iso_mode;
      v[`LOW_OVERRUN]    = s.overrun & s.iso_mode;
      v[`LOW_FIFO_FULL]  = full;
      v[`LOW_PKT_READY]  = s.pkt_ready;
    end else if (hit(addr, `RX_EP1_HIGH_IDX)) begin
      v[`HIGH_AUTO_CLEAR] = s.auto_clr[0];
    end else if (hit(addr, `RX_EP2_HIGH_IDX)) begin
      v[`HIGH_AUTO_CLEAR] = s.auto_clr[1];
    end else if (hit(addr, `RX_EP3_HIGH_IDX)) begin
      v[`HIGH_AUTO_CLEAR] = s.auto_clr[2];
    end else if (hit(addr, `IRQ_STAT_IDX)) begin
      v = {5'h00, s.irq_stat};
    end else if (hit(addr, `IRQ_MASK_IDX)) begin
      v = {5'h00, s.irq_mask};
    end else if (hit(addr, `MODE_CFG_IDX)) begin
      v = {6'h00, s.iso_mode, s.host_mode};
    end else if (hit(addr, `MAXP_IDX)) begin
      v = s.max_pkt[7:0];
    end
    rd_mux = v;
  endfunction

  // ********************************************************
  // Write decode helpers
  // ********************************************************

  // A write takes effect in the cycle waitrequest is low
  assign do_wr  = write_i && (st.phase == BUS_ACK) && byteenable_i[0];
  assign wd     = writedata_i[7:0];
  assign low_wr = do_wr && hit(address_i, `RX_EP1_LOW_IDX);
  // Packet-ready clear sources: software zero, flush, auto-clear
  assign auto_hit = st.host_mode && st.auto_clr[0] && evt_i.unload_done
                    && len_clears(evt_i.unload_len, st.max_pkt, evt_i.unload_dma);
  assign ready_clr = (low_wr && (!wd[`LOW_PKT_READY] || wd[`LOW_FLUSH])) || auto_hit;

  // ********************************************************
  // Next-state logic
  // ********************************************************

  // Bus handshake, register writes and flag updates
  always_comb begin
    next_st         = st;
    next_st.clr_tog = 1'b0;
    next_st.flush   = 1'b0;
    // Hold one cycle, then answer with read data ready
    if (st.phase == BUS_HOLD && (read_i || write_i)) begin
      next_st.phase = BUS_ACK;
      next_st.rdata = {24'h000000, rd_mux(st, address_i, evt_i.fifo_full)};
    end else begin
      next_st.phase = BUS_HOLD;
    end
    // Low control byte writes
    if (low_wr) begin
      next_st.clr_tog   = wd[`LOW_CLR_TOGGLE];
      next_st.stall_req = wd[`LOW_SEND_STALL];
      next_st.flush     = wd[`LOW_FLUSH];
      if (!wd[`LOW_STALL_SENT]) begin
        next_st.stall_sent = 1'b0;
      end
      if (!wd[`LOW_OVERRUN]) begin
        next_st.overrun = 1'b0;
      end
    end
    // High bytes and own configuration registers
    if (do_wr && hit(address_i, `RX_EP1_HIGH_IDX)) begin
      next_st.auto_clr[0] = wd[`HIGH_AUTO_CLEAR];
    end
    if (do_wr && hit(address_i, `RX_EP2_HIGH_IDX)) begin
      next_st.auto_clr[1] = wd[`HIGH_AUTO_CLEAR];
    end
    if (do_wr && hit(address_i, `RX_EP3_HIGH_IDX)) begin
      next_st.auto_clr[2] = wd[`HIGH_AUTO_CLEAR];
    end
    if (do_wr && hit(address_i, `IRQ_MASK_IDX)) begin
      next_st.irq_mask = wd[2:0];
    end
    if (do_wr && hit(address_i, `MODE_CFG_IDX)) begin
      next_st.host_mode = wd[`MODE_HOST];
      next_st.iso_mode  = wd[`MODE_ISO];
    end
    if (do_wr && hit(address_i, `MAXP_IDX)) begin
      next_st.max_pkt[7:0] = wd;
    end
    if (write_i && st.phase == BUS_ACK && byteenable_i[1] && hit(address_i, `MAXP_IDX)) begin
      next_st.max_pkt[10:8] = writedata_i[10:8];
    end
    // Interrupt status: write one to clear, then events set
    if (do_wr && hit(address_i, `IRQ_STAT_IDX)) begin
      next_st.irq_stat = st.irq_stat & ~wd[2:0];
    end
    // Packet-ready and data error; a new packet wins over a clear
    if (ready_clr) begin
      next_st.pkt_ready = 1'b0;
      next_st.data_err  = 1'b0;
    end
    if (evt_i.pkt_rx) begin
      next_st.pkt_ready = 1'b1;
      next_st.data_err  = st.iso_mode && evt_i.crc_err;
      if (!st.pkt_ready || ready_clr) begin
        next_st.irq_stat[`IRQ_PKT_READY] = 1'b1;
      end
    end
    // Stall-sent and overrun events win over software clears
    if (evt_i.stall_sent && !st.host_mode) begin
      next_st.stall_sent                = 1'b1;
      next_st.irq_stat[`IRQ_STALL_SENT] = 1'b1;
    end
    if (evt_i.pkt_drop && st.iso_mode && !st.host_mode) begin
      next_st.overrun                 = 1'b1;
      next_st.irq_stat[`IRQ_OVERRUN]  = 1'b1;
    end
    // Stall answer is suppressed for isochronous endpoints
    next_st.stall_hs = next_st.stall_req && !next_st.iso_mode && !next_st.host_mode;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  // ********************************************************
  // State register
  // ********************************************************

  // Synchronous reset to documented values
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign readdata_o     = st.rdata;
  assign waitrequest_o  = (st.phase == BUS_HOLD);
  assign toggle_clear_o = st.clr_tog;
  assign send_stall_o   = st.stall_hs;
  assign fifo_flush_o   = st.flush;
  assign irq_o          = st.irq;

  // ********************************************************
  // Assertions
  // ********************************************************

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  // Clear-toggle write pulses the toggle clear next cycle
  property p_clr_toggle;
    low_wr && wd[`LOW_CLR_TOGGLE] |=> toggle_clear_o ##1 !toggle_clear_o;
  endproperty
  a_clr_toggle: assert property (p_clr_toggle) else $error("toggle clear missing");

  // Transmitted STALL sets the stall-sent flag
  property p_stall_sent;
    evt_i.stall_sent && !st.host_mode |=> st.stall_sent;
  endproperty
  a_stall_sent: assert property (p_stall_sent) else $error("stall sent not set");

  // Send-stall in device bulk mode drives the stall answer
  property p_send_stall;
    st.stall_req && !st.iso_mode && !st.host_mode |-> send_stall_o;
  endproperty
  a_send_stall: assert property (p_send_stall) else $error("stall not issued");

  // No stall answer in isochronous mode
  property p_iso_no_stall;
    st.iso_mode |-> !send_stall_o;
  endproperty
  a_iso_no_stall: assert property (p_iso_no_stall) else $error("stall in iso");

  // Flush pulses once and drops packet-ready unless a packet arrives
  property p_flush;
    low_wr && wd[`LOW_FLUSH] && !evt_i.pkt_rx |=> fifo_flush_o && !st.pkt_ready;
  endproperty
  a_flush: assert property (p_flush) else $error("flush failed");

  // Data error drops with packet-ready
  property p_data_err;
    $fell(st.pkt_ready) |-> !st.data_err;
  endproperty
  a_data_err: assert property (p_data_err) else $error("data error stuck");

  // Lost iso packet sets overrun
  property p_overrun;
    evt_i.pkt_drop && st.iso_mode && !st.host_mode |=> st.overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not set");

  // Low-byte read returns the FIFO-full level of the request cycle
  property p_full_read;
    read_i && st.phase == BUS_HOLD && hit(address_i, `RX_EP1_LOW_IDX)
      |=> readdata_o[`LOW_FIFO_FULL] == $past(evt_i.fifo_full) && !waitrequest_o;
  endproperty
  a_full_read: assert property (p_full_read) else $error("full flag misread");

  // Received packet sets packet-ready and, from idle, the interrupt bit
  property p_ready_irq;
    evt_i.pkt_rx && !st.pkt_ready |=> st.pkt_ready && st.irq_stat[`IRQ_PKT_READY];
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("ready or irq missing");

  // Auto-clear drops packet-ready when no new packet arrives
  property p_auto_clear;
    auto_hit && !evt_i.pkt_rx |=> !st.pkt_ready;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto clear failed");

  // Writing one to a flag keeps it
  property p_w1_keeps;
    low_wr && wd[`LOW_STALL_SENT] && st.stall_sent |=> st.stall_sent;
  endproperty
  a_w1_keeps: assert property (p_w1_keeps) else $error("flag lost on one");

  // Interrupt output follows the unmasked status bits
  property p_irq_level;
    irq_o == |(st.irq_stat & st.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  // Clearing send-stall ends the stall answer
  property p_stall_clear;
    !st.stall_req |-> !send_stall_o;
  endproperty
  a_stall_clear: assert property (p_stall_clear) else $error("stall not ended");

  // Lost packet in bulk mode leaves overrun clear
  property p_bulk_overrun;
    evt_i.pkt_drop && !st.iso_mode && !st.overrun |=> !st.overrun;
  endproperty
  a_bulk_overrun: assert property (p_bulk_overrun) else $error("overrun in bulk");

  // Short software unload leaves packet-ready for a manual clear
  property p_short_keeps;
    st.pkt_ready && st.host_mode && st.auto_clr[0] && evt_i.unload_done && !evt_i.unload_dma
      && evt_i.unload_len != st.max_pkt && !low_wr |=> st.pkt_ready;
  endproperty
  a_short_keeps: assert property (p_short_keeps) else $error("short packet cleared");

  // STALL seen in host mode leaves stall-sent clear
  property p_host_stall;
    evt_i.stall_sent && st.host_mode && !st.stall_sent |=> !st.stall_sent;
  endproperty
  a_host_stall: assert property (p_host_stall) else $error("stall sent in host");

  // Main scenarios
  c_stall: cover property (send_stall_o ##[1:20] st.stall_sent);
  c_auto: cover property (st.pkt_ready ##1 auto_hit ##1 !st.pkt_ready);
  c_irq: cover property ($rose(irq_o));
  c_flush: cover property (fifo_flush_o);
  c_dma: cover property (auto_hit && evt_i.unload_dma);

endmodule
`default_nettype wire

/* File: usb_rx_ep_params.svh */
// Register indices, field positions and reset values of the receive endpoint control block
`ifndef USB_RX_EP_PARAMS_SVH
`define USB_RX_EP_PARAMS_SVH

// Register indices; the byte address is four times the index
`define RX_EP1_LOW_IDX   10'h116
`define RX_EP1_HIGH_IDX  10'h117
`define RX_EP2_HIGH_IDX  10'h127
`define RX_EP3_HIGH_IDX  10'h137
`define IRQ_STAT_IDX     10'h140
`define IRQ_MASK_IDX     10'h141
`define MODE_CFG_IDX     10'h142
`define MAXP_IDX         10'h143

// Low control/status byte fields
`define LOW_CLR_TOGGLE   7
`define LOW_STALL_SENT   6
`define LOW_SEND_STALL   5
`define LOW_FLUSH        4
`define LOW_DATA_ERR     3
`define LOW_OVERRUN      2
`define LOW_FIFO_FULL    1
`define LOW_PKT_READY    0

// High control/status byte field
`define HIGH_AUTO_CLEAR  7

// Mode register fields
`define MODE_HOST        0
`define MODE_ISO         1

// Interrupt status and mask fields
`define IRQ_PKT_READY    0
`define IRQ_STALL_SENT   1
`define IRQ_OVERRUN      2

// Reset values
`define CTL_RESET        8'h00
`define MAXP_RESET       11'h040

// Unit of a DMA unload in bytes
`define DMA_UNIT_BYTES   3'h4

`endif

/* File: usb_rx_ep_pkg.sv */
// Types shared by the receive endpoint control block
package usb_rx_ep_pkg;

  // Bus handshake phase: hold waitrequest, then answer for one cycle
  typedef enum logic {
    BUS_HOLD = 1'b0,
    BUS_ACK  = 1'b1
  } bus_phase_t;

  // Events from the packet engine facing the USB link
  typedef struct packed {
    logic        pkt_rx;      // Packet stored in the receive FIFO
    logic        crc_err;     // That packet had a CRC or bit-stuff error
    logic        pkt_drop;    // OUT packet could not be stored
    logic        stall_sent;  // STALL handshake transmitted
    logic        fifo_full;   // No room for another packet
    logic        unload_done; // Software or DMA finished unloading a packet
    logic        unload_dma;  // Unload was done by DMA in 4-byte units
    logic [10:0] unload_len;  // Packet length that was unloaded
  } link_evt_t;

  // Whole state of the block
  typedef struct packed {
    bus_phase_t  phase;
    logic [31:0] rdata;
    logic        clr_tog;
    logic        stall_req;
    logic        stall_hs;
    logic        stall_sent;
    logic        flush;
    logic        data_err;
    logic        overrun;
    logic        pkt_ready;
    logic [2:0]  auto_clr;
    logic        host_mode;
    logic        iso_mode;
    logic [10:0] max_pkt;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
  } ctl_state_t;

endpackage

/* File: usb_rx_host_model.sv */
// Far-side model: USB host traffic and packet engine events for the receive endpoint
`timescale 1ns/1ps
`default_nettype none
module usb_rx_host_model (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     srst_i,
  // From the endpoint control block
  input  wire logic                     send_stall_i,
  input  wire logic                     toggle_clear_i,
  input  wire logic                     fifo_flush_i,
  // Events into the block
  output var  usb_rx_ep_pkg::link_evt_t evt_o
);
  import usb_rx_ep_pkg::*;
  logic data_tog;
  int   flush_cnt;
  initial evt_o = '0;
  // Data toggle flips per accepted packet, forced to zero on request
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || toggle_clear_i) data_tog <= 1'b0;
    else if (evt_o.pkt_rx) data_tog <= ~data_tog;
  end
  // Count discard requests seen from the block
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) flush_cnt <= 0;
    else if (fifo_flush_i) flush_cnt <= flush_cnt + 1;
  end
  // One-edge pulse; qualifiers show the inverse once released
  task automatic pulse(input link_evt_t e);
    link_evt_t z;
    e.fifo_full = evt_o.fifo_full;
    z = ~e;
    z.pkt_rx = 1'b0;
    z.pkt_drop = 1'b0;
    z.stall_sent = 1'b0;
    z.unload_done = 1'b0;
    z.fifo_full = e.fifo_full;
    @(posedge clk_sys_i);
    evt_o <= e;
    @(posedge clk_sys_i);
    evt_o <= z;
    @(posedge clk_sys_i);
  endtask
  // OUT transaction: stalled endpoint gets a STALL, else a packet lands
  task automatic out_xfer(input logic crc);
    link_evt_t e;
    e = '0;
    if (send_stall_i) e.stall_sent = 1'b1;
    else begin
      e.pkt_rx = 1'b1;
      e.crc_err = crc;
    end
    pulse(e);
  endtask
  // OUT packet that finds no room
  task automatic drop();
    link_evt_t e;
    e = '0;
    e.pkt_drop = 1'b1;
    pulse(e);
  endtask
  // Packet unloaded, by DMA in 4-byte units or by software
  task automatic unload(input logic dma, input logic [10:0] len);
    link_evt_t e;
    e = '0;
    e.unload_done = 1'b1;
    e.unload_dma = dma;
    e.unload_len = len;
    pulse(e);
  endtask
  // FIFO has no room for another packet
  task automatic set_full(input logic v);
    @(posedge clk_sys_i);
    evt_o.fifo_full <= v;
  endtask
endmodule
`default_nettype wire
